/* rtl/file_register_op_execute.sv */
// Two-stage executor for three byte-oriented file-register instructions
`timescale 1ns/1ps
`default_nettype none
module file_register_op_execute
	import file_register_op_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_instr_valid,
	input wire logic [INSTR_W-1:0] i_instr,
	input wire logic i_load_en,
	input wire logic [ADDR_W-1:0] i_load_addr,
	input wire logic [DATA_W-1:0] i_load_data,
	input wire logic i_work_load_en,
	input wire logic [DATA_W-1:0] i_work_load_data,
	output logic [DATA_W-1:0] o_work,
	output logic o_zero,
	output logic o_done,
	output logic o_skip,
	output logic o_annulled,
	output logic o_unsupported,
	output logic o_file_we,
	output logic [ADDR_W-1:0] o_file_addr,
	output logic [DATA_W-1:0] o_file_data
);

	function automatic op_kind_t decode_op(input logic [INSTR_W-1:0] word);
		op_kind_t kind;
		kind = OP_NONE;
		if (word[CLASS_MSB:CLASS_LSB] == CLASS_BYTE_OP) begin // see RULE_06
			case (word[OPC_MSB:OPC_LSB])
				OPC_DEC_SKIP: kind = OP_DEC_SKIP;
				OPC_OR_WORK: kind = OP_OR_WORK;
				OPC_MOVE_FILE: kind = OP_MOVE_FILE;
				default: kind = OP_NONE;
			endcase
		end
		return kind;
	endfunction

	function automatic logic [ADDR_W-1:0] addr_of(
		input logic [INSTR_W-1:0] word);
		return word[ADDR_MSB:ADDR_LSB]; // see RULE_06
	endfunction

	// Execute stage
	logic ex_valid_reg;
	logic ex_valid_next;
	op_kind_t ex_op_reg;
	op_kind_t ex_op_next;
	logic ex_dest_reg;
	logic ex_dest_next;
	logic [ADDR_W-1:0] ex_addr_reg;
	logic [ADDR_W-1:0] ex_addr_next;

	// Architectural state and forwarding
	logic [DATA_W-1:0] w_reg;
	logic [DATA_W-1:0] w_next;
	logic z_reg;
	logic z_next;
	logic skip_reg;
	logic skip_next;
	logic fwd_valid_reg;
	logic fwd_valid_next;
	logic [ADDR_W-1:0] fwd_addr_reg;
	logic [ADDR_W-1:0] fwd_addr_next;
	logic [DATA_W-1:0] fwd_data_reg;
	logic [DATA_W-1:0] fwd_data_next;

	// Registered event outputs
	logic done_next;
	logic skip_ev_next;
	logic annul_next;
	logic unsup_next;

	// Memory port wiring
	logic mem_we;
	logic [ADDR_W-1:0] mem_waddr;
	logic [DATA_W-1:0] mem_wdata;
	logic [ADDR_W-1:0] mem_raddr;
	logic [DATA_W-1:0] mem_rdata;

	// Execute datapath
	logic [DATA_W-1:0] file_val;
	logic [DATA_W-1:0] result;
	logic result_zero;
	logic annul;
	logic exec_live;
	logic write_file;
	logic write_work;

	file_reg_mem u_mem (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_we(mem_we),
		.i_waddr(mem_waddr),
		.i_wdata(mem_wdata),
		.i_raddr(mem_raddr),
		.o_rdata(mem_rdata)
	);

	// Decode stage: operand read is launched as the word is taken
	always_comb begin
		mem_raddr = addr_of(i_instr);
		ex_valid_next = i_instr_valid;
		ex_op_next = decode_op(i_instr);
		ex_dest_next = i_instr[DEST_BIT];
		ex_addr_next = addr_of(i_instr);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ex_valid_reg <= 1'b0;
			ex_op_reg <= OP_NONE;
			ex_dest_reg <= DEST_WORK;
			ex_addr_reg <= ADDR_RST;
		end else begin
			ex_valid_reg <= ex_valid_next;
			ex_op_reg <= ex_op_next;
			ex_dest_reg <= ex_dest_next;
			ex_addr_reg <= ex_addr_next;
		end
	end

	// The read was launched before the previous write landed, so the
	// last written word is forwarded instead of stalling the pipe
	always_comb begin
		if (fwd_valid_reg && (fwd_addr_reg == ex_addr_reg)) begin
			file_val = fwd_data_reg;
		end else begin
			file_val = mem_rdata;
		end
	end

	// Prefetched word after a zero decrement becomes a no-operation
	always_comb begin
		annul = ex_valid_reg && skip_reg; // see RULE_01
		exec_live = ex_valid_reg && !skip_reg && (ex_op_reg != OP_NONE);
	end

	always_comb begin
		case (ex_op_reg)
			OP_DEC_SKIP: result = file_val - DATA_ONE; // see RULE_01
			OP_OR_WORK: result = w_reg | file_val; // see RULE_03
			OP_MOVE_FILE: result = file_val; // see RULE_04
			default: result = file_val;
		endcase
		result_zero = (result == DATA_ZERO);
	end

	always_comb begin
		write_file = exec_live && (ex_dest_reg == DEST_FILE); // see RULE_02
		write_work = exec_live && (ex_dest_reg == DEST_WORK); // see RULE_02
	end

	// Execute write wins the single write port over a preload
	always_comb begin
		if (write_file) begin
			mem_we = 1'b1;
			mem_waddr = ex_addr_reg;
			mem_wdata = result;
		end else begin
			mem_we = i_load_en;
			mem_waddr = i_load_addr;
			mem_wdata = i_load_data;
		end
		fwd_valid_next = mem_we;
		fwd_addr_next = mem_waddr;
		fwd_data_next = mem_wdata;
	end

	always_comb begin
		w_next = w_reg;
		if (write_work) begin
			w_next = result;
		end else if (i_work_load_en) begin
			w_next = i_work_load_data;
		end
	end

	// Decrement-and-skip leaves the zero flag alone
	always_comb begin
		z_next = z_reg;
		if (exec_live && (ex_op_reg == OP_OR_WORK)) begin
			z_next = result_zero; // see RULE_03
		end else if (exec_live && (ex_op_reg == OP_MOVE_FILE)) begin
			z_next = result_zero; // see RULE_05
		end
	end

	// A pending skip waits for the next taken word, however late
	always_comb begin
		skip_next = skip_reg;
		if (annul) begin
			skip_next = 1'b0;
		end else if (exec_live && (ex_op_reg == OP_DEC_SKIP) && result_zero) begin
			skip_next = 1'b1; // see RULE_01
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			w_reg <= WORK_RST;
			z_reg <= ZERO_RST;
			skip_reg <= 1'b0;
			fwd_valid_reg <= 1'b0;
			fwd_addr_reg <= ADDR_RST;
			fwd_data_reg <= DATA_ZERO;
		end else begin
			w_reg <= w_next;
			z_reg <= z_next;
			skip_reg <= skip_next;
			fwd_valid_reg <= fwd_valid_next;
			fwd_addr_reg <= fwd_addr_next;
			fwd_data_reg <= fwd_data_next;
		end
	end

	always_comb begin
		done_next = ex_valid_reg;
		skip_ev_next = exec_live && (ex_op_reg == OP_DEC_SKIP) && result_zero;
		annul_next = annul;
		unsup_next = ex_valid_reg && !skip_reg && (ex_op_reg == OP_NONE);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_done <= 1'b0;
			o_skip <= 1'b0;
			o_annulled <= 1'b0;
			o_unsupported <= 1'b0;
			o_file_we <= 1'b0;
			o_file_addr <= ADDR_RST;
			o_file_data <= DATA_ZERO;
		end else begin
			o_done <= done_next;
			o_skip <= skip_ev_next;
			o_annulled <= annul_next;
			o_unsupported <= unsup_next;
			o_file_we <= write_file;
			o_file_addr <= ex_addr_reg;
			o_file_data <= result;
		end
	end

	always_comb begin
		o_work = w_reg;
		o_zero = z_reg;
	end

endmodule
`default_nettype wire

/* include/file_register_op_pkg.sv */
// Constants and types shared by the file-register instruction executor
// Behaviour
// RULE_01: Decrement, write, skip next word on zero
// RULE_02: Destination bit zero selects work, one selects file
// RULE_03: OR work with file, store, update zero
// RULE_04: Move file to work, or rewrite file itself
// RULE_05: Move updates zero flag from moved value
// RULE_06: Word is 00, opcode, destination, seven-bit address
package file_register_op_pkg;

	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int FILE_DEPTH = 128;

	localparam int CLASS_MSB = 13;
	localparam int CLASS_LSB = 12;
	localparam int OPC_MSB = 11;
	localparam int OPC_LSB = 8;
	localparam int DEST_BIT = 7;
	localparam int ADDR_MSB = 6;
	localparam int ADDR_LSB = 0;

	localparam logic [1:0] CLASS_BYTE_OP = 2'h0;
	localparam logic [3:0] OPC_DEC_SKIP = 4'hb;
	localparam logic [3:0] OPC_OR_WORK = 4'h4;
	localparam logic [3:0] OPC_MOVE_FILE = 4'h8;

	localparam logic DEST_WORK = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [7:0] DATA_ZERO = 8'h00;
	localparam logic [7:0] DATA_ONE = 8'h01;
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic ZERO_RST = 1'b0;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_DEC_SKIP,
		OP_OR_WORK,
		OP_MOVE_FILE
	} op_kind_t;

endpackage

/* rtl/file_reg_mem.sv */
// File register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module file_reg_mem
	import file_register_op_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_we,
	input wire logic [ADDR_W-1:0] i_waddr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic [ADDR_W-1:0] i_raddr,
	output logic [DATA_W-1:0] o_rdata
);

	logic [DATA_W-1:0] mem_reg [FILE_DEPTH];
	logic [DATA_W-1:0] rdata_next;

	// Read returns the old word when the same address is written
	always_comb begin
		rdata_next = mem_reg[i_raddr];
	end

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem_reg[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rdata <= DATA_ZERO;
		end else begin
			o_rdata <= rdata_next;
		end
	end

endmodule
`default_nettype wire

/* tb/op_exec_monitor.sv */
// Assertion checker for the file-register executor
`timescale 1ns/1ps
`default_nettype none
module op_exec_monitor
	import file_register_op_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_instr_valid,
	input wire logic [INSTR_W-1:0] i_instr,
	input wire logic [DATA_W-1:0] o_work,
	input wire logic o_zero,
	input wire logic o_done,
	input wire logic o_skip,
	input wire logic o_annulled,
	input wire logic o_unsupported,
	input wire logic o_file_we,
	input wire logic [ADDR_W-1:0] o_file_addr,
	input wire logic [DATA_W-1:0] o_file_data
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	property p_lat;
		i_instr_valid |-> ##2 o_done;
	endproperty
	a_lat: assert property (p_lat) else $error("done late");
	property p_idle;
		!i_instr_valid |-> ##2 !o_done;
	endproperty
	a_idle: assert property (p_idle) else $error("stray done");
	property p_annul;
		o_skip ##1 o_done |-> o_annulled;
	endproperty
	a_annul: assert property (p_annul) else $error("no annul");
	property p_skipz;
		o_skip |-> (o_file_we ? o_file_data : o_work) == DATA_ZERO;
	endproperty
	a_skipz: assert property (p_skipz) else $error("bad skip");
	property p_dest;
		o_file_we |-> $past(i_instr[DEST_BIT], 2)
			&& o_file_addr == $past(i_instr[ADDR_MSB:ADDR_LSB], 2);
	endproperty
	a_dest: assert property (p_dest) else $error("bad dest");
	property p_unsup;
		i_instr_valid && i_instr[CLASS_MSB:CLASS_LSB] != CLASS_BYTE_OP
			|-> ##2 (o_unsupported || o_annulled);
	endproperty
	a_unsup: assert property (p_unsup) else $error("bad class");
	property p_zflag;
		o_done && !o_annulled && !o_unsupported
			&& $past(i_instr[OPC_MSB:OPC_LSB], 2) != OPC_DEC_SKIP
			|-> o_zero == ((o_file_we ? o_file_data : o_work) == DATA_ZERO);
	endproperty
	a_zflag: assert property (p_zflag) else $error("bad zero");
	property p_movw;
		o_file_we && $past(i_instr[OPC_MSB:OPC_LSB], 2) == OPC_MOVE_FILE
			|-> $stable(o_work);
	endproperty
	a_movw: assert property (p_movw) else $error("work moved");
	property p_nop;
		o_annulled |-> !o_file_we && $stable(o_work) && $stable(o_zero);
	endproperty
	a_nop: assert property (p_nop) else $error("nop acted");
endmodule
bind file_register_op_execute op_exec_monitor mon (.i_clk, .i_sys_rst,
	.i_instr_valid, .i_instr, .o_work, .o_zero, .o_done, .o_skip,
	.o_annulled, .o_unsupported, .o_file_we, .o_file_addr, .o_file_data);
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the file-register executor
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import file_register_op_pkg::*;
;
	logic i_clk = 0, i_sys_rst = 1, i_instr_valid = 0;
	logic [13:0] i_instr = '0;
	logic i_load_en = 0, i_work_load_en = 0;
	logic [6:0] i_load_addr = '0, o_file_addr;
	logic [7:0] i_load_data = '0, i_work_load_data = '0;
	logic [7:0] o_work, o_file_data, w = '0, r, f;
	logic o_zero, o_done, o_skip, o_annulled, o_unsupported, o_file_we;
	logic z = 0, pend = 0;
	logic [7:0] mem [128];
	logic [27:0] q [$];
	logic [31:0] k;
	wire logic [27:0] obs;
	int seed = 32'h51c361f5, fails = 0, n_checks = 0;
	always #12.5 i_clk = ~i_clk;
	assign obs = {o_annulled, o_unsupported, o_skip, o_file_we,
		o_file_we ? o_file_addr : 7'h00, o_file_we ? o_file_data : 8'h00,
		o_work, o_zero};
	file_register_op_execute uut (.i_clk, .i_sys_rst, .i_instr_valid,
		.i_instr, .i_load_en, .i_load_addr, .i_load_data, .i_work_load_en,
		.i_work_load_data, .o_work, .o_zero, .o_done, .o_skip, .o_annulled,
		.o_unsupported, .o_file_we, .o_file_addr, .o_file_data);
	task automatic chk(input logic [27:0] exp, input logic [27:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] result exp %h got %h", exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Model runs in program order, so forwarding needs no special case
	task automatic issue(input logic [13:0] x);
		logic an, un, we, sk;
		an = pend;
		un = 0;
		we = 0;
		sk = 0;
		r = 8'h00;
		pend = 0;
		f = mem[x[6:0]];
		if (!an && (x[13:12] != CLASS_BYTE_OP || !(x[11:8] inside
			{OPC_DEC_SKIP, OPC_OR_WORK, OPC_MOVE_FILE})))
			un = 1;
		else if (!an) begin
			r = (x[11:8] == OPC_DEC_SKIP) ? f - 8'h01 :
				(x[11:8] == OPC_OR_WORK) ? (w | f) : f;
			if (x[11:8] != OPC_DEC_SKIP)
				z = (r == DATA_ZERO);
			sk = (x[11:8] == OPC_DEC_SKIP) && r == DATA_ZERO;
			pend = sk;
			we = x[DEST_BIT];
			if (we)
				mem[x[6:0]] = r;
			else
				w = r;
		end
		q.push_back({an, un, sk, we, we ? x[6:0] : 7'h00, r & {8{we}}, w, z});
		i_instr_valid = 1;
		i_instr = x;
	endtask
	always @(posedge i_clk) begin
		#1;
		// An unknown done is a mismatch, never a silent pass
		if (o_done !== 1'b0 &&
			(o_done !== 1'b1 || q.size() == 0)) begin
			fails++;
			$display("[ERR] done exp %0d got %b", q.size() != 0, o_done);
		end else if (o_done === 1'b1)
			chk(q.pop_front(), obs);
	end
	initial begin
		#250000;
		fails++;
		$display("[ERR] watchdog exp done got timeout");
		print_verdict;
	end
	initial begin
		repeat (16) @(negedge i_clk);
		i_sys_rst = 0;
		chk(28'h0, obs);
		for (int a = 0; a < 128; a++) begin
			@(negedge i_clk);
			i_load_en = 1;
			i_load_addr = a[6:0];
			i_load_data = 8'($random(seed)) & 8'h03;
			mem[a] = i_load_data;
		end
		// Presets only while idle, since an executing write wins the port
		for (int b = 0; b < 30; b++) begin
			@(negedge i_clk);
			i_load_en = 0;
			i_instr_valid = 0;
			repeat (3) @(negedge i_clk);
			i_work_load_en = 1;
			i_work_load_data = 8'($random(seed));
			w = i_work_load_data;
			@(negedge i_clk);
			i_work_load_en = 0;
			repeat (60) begin
				@(negedge i_clk);
				k = $random(seed);
				if (k[4:2] != 3'h0)
					issue({k[10:8] == 3'h0 ? k[12:11] : 2'b00, k[1:0] == 2'h3 ?
						k[7:4] : k[0] ? OPC_OR_WORK : k[1] ? OPC_MOVE_FILE :
						OPC_DEC_SKIP, k[13], 4'h0, k[16:14]});
				else
					i_instr_valid = 0;
			end
		end
		@(negedge i_clk);
		i_instr_valid = 0;
		repeat (4) @(negedge i_clk);
		if (q.size() != 0) begin
			fails++;
			$display("[ERR] pending exp 0 got %0d", q.size());
		end
		print_verdict;
	end
endmodule
`default_nettype wire
